// *** common/bit_ops_pkg.sv ***
// package of constants and types for the bit, shift and flag unit
package bit_ops_pkg;
	localparam int DATA_W = 8;
	localparam int FLAG_W = 8;
	// status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// register index of the status flags in the register port
	localparam logic [1:0] REG_STATUS_FLAGS = 2'h0;
	localparam logic [1:0] REG_LAST_RESULT = 2'h1;
	localparam logic [1:0] REG_OP_COUNT = 2'h2;
	localparam int OP_CYCLES = 1;
	typedef enum logic [4:0] {
		OP_NONE,
		OP_ROTATE_LEFT,
		OP_ROTATE_RIGHT,
		OP_ARITH_RIGHT_SHIFT,
		OP_NIBBLE_SWAP,
		OP_FLAG_FORCE_ONE,
		OP_FLAG_FORCE_ZERO,
		OP_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_BIT,
		OP_CARRY_RAISE,
		OP_CARRY_DROP,
		OP_NEGATIVE_RAISE,
		OP_NEGATIVE_DROP,
		OP_ZERO_RAISE,
		OP_ZERO_DROP,
		OP_IRQ_ENABLE_RAISE,
		OP_IRQ_ENABLE_DROP,
		OP_SIGN_RAISE,
		OP_SIGN_DROP,
		OP_OVERFLOW_RAISE,
		OP_OVERFLOW_DROP,
		OP_TRANSFER_FLAG_RAISE,
		OP_TRANSFER_FLAG_DROP,
		OP_BREAK
	} op_e;
endpackage : bit_ops_pkg

// *** common/shift_unit_if.sv ***
// interface between the flag unit and its shift datapath
`timescale 1ns/1ns
interface shift_unit_if;
	logic [7:0] operand;
	logic carry_in;
	bit_ops_pkg::op_e op;
	logic [7:0] result;
	logic carry_out;
	logic overflow_out;
	modport ctrl (output operand, output carry_in, output op,
		input result, input carry_out, input overflow_out);
	modport dp (input operand, input carry_in, input op,
		output result, output carry_out, output overflow_out);
endinterface : shift_unit_if

// *** hw/shift_datapath.sv ***
// combinational rotate, shift and swap datapath
`timescale 1ns/1ns
module shift_datapath (
	shift_unit_if.dp su
);
	always_comb begin
		su.result = su.operand;
		su.carry_out = su.carry_in;
		case (su.op)
			bit_ops_pkg::OP_ROTATE_LEFT: begin
				su.result = {su.operand[6:0], su.carry_in}; // RULE_01
				su.carry_out = su.operand[7]; // RULE_01
			end
			bit_ops_pkg::OP_ROTATE_RIGHT: begin
				su.result = {su.carry_in, su.operand[7:1]}; // RULE_02
				su.carry_out = su.operand[0]; // RULE_02
			end
			bit_ops_pkg::OP_ARITH_RIGHT_SHIFT: begin
				su.result = {su.operand[7], su.operand[7:1]}; // RULE_03 RULE_04
				su.carry_out = su.operand[0]; // RULE_04
			end
			bit_ops_pkg::OP_NIBBLE_SWAP: begin
				su.result = {su.operand[3:0], su.operand[7:4]}; // RULE_05
			end
			default: begin
			end
		endcase
		// overflow is negative xor carry of the result
		su.overflow_out = su.result[7] ^ su.carry_out; // RULE_06
	end
endmodule : shift_datapath

// *** hw/bit_shift_flag_ops.sv ***
// bit, shift and status flag execution unit
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ns
//
// Overview of operation
// (RULE_01) rotate left through carry: bit0 from carry, carry from old bit7
// (RULE_02) rotate right through carry: bit7 from carry, carry from old bit0
// (RULE_03) arithmetic right shift moves bit n+1 into bit n for n 0..6
// (RULE_04) arithmetic right shift keeps bit7 and puts old bit0 in carry
// (RULE_05) nibble swap exchanges the halves and leaves every flag alone
// (RULE_06) rotates and arithmetic shift update zero, carry, negative, overflow
// (RULE_07) generic flag set/clear writes one/zero into flag selected by s only
// (RULE_08) bit store copies source bit b to transfer flag; load copies it back
// (RULE_09) single-flag ops force carry, negative, zero, sign, overflow alone
// (RULE_10) dedicated ops force the transfer flag alone
// (RULE_11) dedicated ops raise or drop the global interrupt enable
// (RULE_12) breakpoint acts only for on-chip debug, no normal execution effect
// (RULE_13) every operation here completes in one clock cycle
module bit_shift_flag_ops (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic op_valid_i,
	input wire bit_ops_pkg::op_e op_i,
	input wire logic [7:0] operand_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic debug_enable_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic [7:0] result_o,
	output logic result_valid_o,
	output logic [7:0] flags_o,
	output logic break_o
);
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] result_q;
	logic [7:0] result_d;
	logic result_wr_d;
	logic result_valid_q;
	logic break_q;
	logic [7:0] op_count_q;
	logic [7:0] rdata_q;
	shift_unit_if su ();

	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction : bit_mask

	shift_datapath u_shift (
		.su(su.dp)
	);

	assign su.operand = operand_i;
	assign su.carry_in = flags_q[bit_ops_pkg::FLAG_C];
	assign su.op = op_i;

	always_comb begin
		flags_d = flags_q;
		result_d = su.result;
		result_wr_d = 1'b0;
		case (op_i)
			bit_ops_pkg::OP_ROTATE_LEFT,
			bit_ops_pkg::OP_ROTATE_RIGHT,
			bit_ops_pkg::OP_ARITH_RIGHT_SHIFT: begin
				result_wr_d = 1'b1;
				flags_d[bit_ops_pkg::FLAG_C] = su.carry_out; // RULE_06
				flags_d[bit_ops_pkg::FLAG_Z] = (su.result == 8'h00); // RULE_06
				flags_d[bit_ops_pkg::FLAG_N] = su.result[7]; // RULE_06
				flags_d[bit_ops_pkg::FLAG_V] = su.overflow_out; // RULE_06
			end
			bit_ops_pkg::OP_NIBBLE_SWAP: begin
				result_wr_d = 1'b1; // RULE_05
			end
			bit_ops_pkg::OP_FLAG_FORCE_ONE: begin
				flags_d = flags_q | bit_mask(bit_sel_i); // RULE_07
			end
			bit_ops_pkg::OP_FLAG_FORCE_ZERO: begin
				flags_d = flags_q & ~bit_mask(bit_sel_i); // RULE_07
			end
			bit_ops_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
				flags_d[bit_ops_pkg::FLAG_T] = operand_i[bit_sel_i]; // RULE_08
			end
			bit_ops_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
				result_wr_d = 1'b1;
				result_d = flags_q[bit_ops_pkg::FLAG_T] ? (operand_i | bit_mask(bit_sel_i))
					: (operand_i & ~bit_mask(bit_sel_i)); // RULE_08
			end
			bit_ops_pkg::OP_CARRY_RAISE: flags_d[bit_ops_pkg::FLAG_C] = 1'b1; // RULE_09
			bit_ops_pkg::OP_CARRY_DROP: flags_d[bit_ops_pkg::FLAG_C] = 1'b0; // RULE_09
			bit_ops_pkg::OP_NEGATIVE_RAISE: flags_d[bit_ops_pkg::FLAG_N] = 1'b1; // RULE_09
			bit_ops_pkg::OP_NEGATIVE_DROP: flags_d[bit_ops_pkg::FLAG_N] = 1'b0; // RULE_09
			bit_ops_pkg::OP_ZERO_RAISE: flags_d[bit_ops_pkg::FLAG_Z] = 1'b1; // RULE_09
			bit_ops_pkg::OP_ZERO_DROP: flags_d[bit_ops_pkg::FLAG_Z] = 1'b0; // RULE_09
			bit_ops_pkg::OP_SIGN_RAISE: flags_d[bit_ops_pkg::FLAG_S] = 1'b1; // RULE_09
			bit_ops_pkg::OP_SIGN_DROP: flags_d[bit_ops_pkg::FLAG_S] = 1'b0; // RULE_09
			bit_ops_pkg::OP_OVERFLOW_RAISE: flags_d[bit_ops_pkg::FLAG_V] = 1'b1; // RULE_09
			bit_ops_pkg::OP_OVERFLOW_DROP: flags_d[bit_ops_pkg::FLAG_V] = 1'b0; // RULE_09
			bit_ops_pkg::OP_TRANSFER_FLAG_RAISE: flags_d[bit_ops_pkg::FLAG_T] = 1'b1; // RULE_10
			bit_ops_pkg::OP_TRANSFER_FLAG_DROP: flags_d[bit_ops_pkg::FLAG_T] = 1'b0; // RULE_10
			bit_ops_pkg::OP_IRQ_ENABLE_RAISE: flags_d[bit_ops_pkg::FLAG_I] = 1'b1; // RULE_11
			bit_ops_pkg::OP_IRQ_ENABLE_DROP: flags_d[bit_ops_pkg::FLAG_I] = 1'b0; // RULE_11
			default: begin
			end
		endcase
	end

	// status flags: one instruction per cycle, register writes lose to it
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			flags_q <= bit_ops_pkg::FLAGS_RESET;
		end else if (op_valid_i) begin
			flags_q <= flags_d; // RULE_13
		end else if (reg_wr_i && reg_addr_i == bit_ops_pkg::REG_STATUS_FLAGS) begin
			flags_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			result_q <= bit_ops_pkg::DATA_RESET;
			result_valid_q <= 1'b0;
		end else begin
			result_valid_q <= op_valid_i && result_wr_d; // RULE_13
			if (op_valid_i && result_wr_d) begin
				result_q <= result_d;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			break_q <= 1'b0;
		end else begin
			break_q <= op_valid_i && op_i == bit_ops_pkg::OP_BREAK && debug_enable_i; // RULE_12
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			op_count_q <= 8'h00;
		end else if (reg_wr_i && reg_addr_i == bit_ops_pkg::REG_OP_COUNT) begin
			op_count_q <= 8'h00;
		end else if (op_valid_i) begin
			op_count_q <= op_count_q + 8'h01;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				bit_ops_pkg::REG_STATUS_FLAGS: rdata_q <= flags_q;
				bit_ops_pkg::REG_LAST_RESULT: rdata_q <= result_q;
				bit_ops_pkg::REG_OP_COUNT: rdata_q <= op_count_q;
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign result_o = result_q;
	assign result_valid_o = result_valid_q;
	assign flags_o = flags_q;
	assign break_o = break_q;
endmodule : bit_shift_flag_ops

// *** tb/bit_ops_monitor.sv ***
// port checker of the bit, shift and flag unit
`timescale 1ns/1ns
module bit_ops_monitor (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic op_valid_i,
	input wire bit_ops_pkg::op_e op_i,
	input wire logic [7:0] operand_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [7:0] result_o,
	input wire logic result_valid_o,
	input wire logic [7:0] flags_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	wire rl = op_valid_i && op_i == bit_ops_pkg::OP_ROTATE_LEFT;
	wire rr = op_valid_i && op_i == bit_ops_pkg::OP_ROTATE_RIGHT;
	wire ar = op_valid_i && op_i == bit_ops_pkg::OP_ARITH_RIGHT_SHIFT;
	wire sw = op_valid_i && op_i == bit_ops_pkg::OP_NIBBLE_SWAP;
	wire fs = op_valid_i && op_i == bit_ops_pkg::OP_FLAG_FORCE_ONE;
	wire fc = op_valid_i && op_i == bit_ops_pkg::OP_FLAG_FORCE_ZERO;
	wire bs = op_valid_i && op_i == bit_ops_pkg::OP_BIT_TO_TRANSFER_FLAG;
	sequence shift_s;
		rl || rr || ar;
	endsequence
	rol_res_a: assert property (rl |=> result_valid_o
		&& flags_o[0] == $past(operand_i[7])
		&& result_o == {$past(operand_i[6:0]), $past(flags_o[0])}) else $error("bad rol");
	ror_res_a: assert property (rr |=> flags_o[0] == $past(operand_i[0])
		&& result_o == {$past(flags_o[0]), $past(operand_i[7:1])}) else $error("bad ror");
	asr_res_a: assert property (ar |=> flags_o[0] == $past(operand_i[0])
		&& result_o == {$past(operand_i[7]), $past(operand_i[7:1])}) else $error("bad asr");
	swap_res_a: assert property (sw |=> flags_o == $past(flags_o)
		&& result_o == {$past(operand_i[3:0]), $past(operand_i[7:4])}) else $error("bad swap");
	shift_flags_a: assert property (shift_s |=> flags_o[1] == (result_o == 8'h00)
		&& flags_o[2] == result_o[7] && flags_o[3] == (result_o[7] ^ flags_o[0])) else $error("bad znv");
	flag_set_a: assert property (fs |=>
		flags_o == ($past(flags_o) | (8'h01 << $past(bit_sel_i)))) else $error("bad set");
	flag_clr_a: assert property (fc |=>
		flags_o == ($past(flags_o) & ~(8'h01 << $past(bit_sel_i)))) else $error("bad clear");
	bit_store_a: assert property (bs |=> flags_o == {$past(flags_o[7]),
		$past(operand_i[bit_sel_i]), $past(flags_o[5:0])}) else $error("bad store");
endmodule : bit_ops_monitor
bind bit_shift_flag_ops bit_ops_monitor bit_ops_monitor_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
	.op_valid_i(op_valid_i), .op_i(op_i), .operand_i(operand_i), .bit_sel_i(bit_sel_i),
	.result_o(result_o), .result_valid_o(result_valid_o), .flags_o(flags_o));

// *** tb/tb.sv ***
// bench of the bit, shift and flag unit
`timescale 1ns/1ns
module tb;
	logic mclk_i, resetn_i, op_valid_i, debug_enable_i, reg_wr_i, reg_rd_i;
	logic result_valid_o, break_o;
	bit_ops_pkg::op_e op_i;
	logic [7:0] operand_i, reg_wdata_i, reg_rdata_o, result_o, flags_o, e;
	logic [2:0] bit_sel_i;
	logic [1:0] reg_addr_i;
	int n_fail = 0, n_tests = 0;
	bit_shift_flag_ops bit_shift_flag_ops_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.op_valid_i(op_valid_i), .op_i(op_i), .operand_i(operand_i), .bit_sel_i(bit_sel_i),
		.debug_enable_i(debug_enable_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.result_o(result_o), .result_valid_o(result_valid_o), .flags_o(flags_o), .break_o(break_o));
	task automatic chk(input logic [7:0] s, input logic [7:0] x);
		n_tests++;
		if (s !== x) begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, s, x);
		end
	endtask : chk
	task automatic run(input bit_ops_pkg::op_e o, input logic [7:0] d, input logic [2:0] b);
		@(posedge mclk_i);
		op_valid_i <= 1'b1;
		op_i <= o;
		operand_i <= d;
		bit_sel_i <= b;
		@(posedge mclk_i);
		op_valid_i <= 1'b0;
		@(negedge mclk_i);
	endtask : run
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] x);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(negedge mclk_i);
		chk(reg_rdata_o, x);
	endtask : rd
	task automatic sh(input bit_ops_pkg::op_e o, input logic [7:0] d, r, f);
		run(o, d, 3'h0);
		chk({7'h00, result_valid_o}, 8'h01);
		chk(result_o, r);
		chk(flags_o & 8'h0f, f);
	endtask : sh
	task automatic t_shift();
		wr(2'h0, 8'h01);
		sh(bit_ops_pkg::OP_ROTATE_RIGHT, 8'h01, 8'h80, 8'h05);
		sh(bit_ops_pkg::OP_ROTATE_LEFT, 8'h80, 8'h01, 8'h09);
		sh(bit_ops_pkg::OP_ARITH_RIGHT_SHIFT, 8'h01, 8'h00, 8'h0b);
		sh(bit_ops_pkg::OP_ARITH_RIGHT_SHIFT, 8'h82, 8'hc1, 8'h0c);
		sh(bit_ops_pkg::OP_ROTATE_LEFT, 8'h80, 8'h00, 8'h0b);
		wr(2'h0, 8'hc3);
		run(bit_ops_pkg::OP_NIBBLE_SWAP, 8'ha5, 3'h0);
		chk(result_o, 8'h5a);
		chk(flags_o, 8'hc3);
		$display("shift done");
	endtask : t_shift
	task automatic t_flags();
		int pos [7] = '{0, 2, 1, 7, 4, 3, 6};
		wr(2'h0, 8'h00);
		e = 8'h00;
		for (int s = 0; s < 16; s++) begin
			e = s < 8 ? e | 8'(1 << s) : e & ~8'(1 << (s - 8));
			run(s < 8 ? bit_ops_pkg::OP_FLAG_FORCE_ONE : bit_ops_pkg::OP_FLAG_FORCE_ZERO, 8'h00, 3'(s));
			chk(flags_o, e);
		end
		for (int i = 0; i < 14; i++) begin
			e = i % 2 ? 8'h00 : 8'(1 << pos[i / 2]);
			run(bit_ops_pkg::op_e'(bit_ops_pkg::OP_CARRY_RAISE + i), 8'h00, 3'h0);
			chk(flags_o, e);
		end
		$display("flags done");
	endtask : t_flags
	task automatic t_bits();
		run(bit_ops_pkg::OP_BIT_TO_TRANSFER_FLAG, 8'h20, 3'h5);
		chk(flags_o, 8'h40);
		chk({7'h00, result_valid_o}, 8'h00);
		run(bit_ops_pkg::OP_TRANSFER_FLAG_TO_BIT, 8'h81, 3'h3);
		chk(result_o, 8'h89);
		chk(flags_o, 8'h40);
		run(bit_ops_pkg::OP_BREAK, 8'h00, 3'h0);
		chk({7'h0, break_o}, 8'h01);
		chk(flags_o, 8'h40);
		wr(2'h0, 8'h5a);
		rd(2'h0, 8'h5a);
		rd(2'h3, 8'h00);
		rd(2'h1, 8'h89);
		wr(2'h2, 8'h00);
		run(bit_ops_pkg::OP_CARRY_RAISE, 8'h00, 3'h0);
		rd(2'h2, 8'h01);
		rd(2'h0, 8'h5b);
		debug_enable_i <= 1'b0;
		run(bit_ops_pkg::OP_BREAK, 8'h00, 3'h0);
		chk({7'h00, break_o}, 8'h00);
		chk(flags_o, 8'h5b);
		$display("bits done");
	endtask : t_bits
	task automatic stop_test();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end
	initial begin
		#200000;
		n_fail++;
		stop_test();
	end
	initial begin
		resetn_i = 1'b0;
		op_valid_i = 1'b0;
		op_i = bit_ops_pkg::OP_NONE;
		operand_i = 8'h00;
		bit_sel_i = 3'h0;
		debug_enable_i = 1'b1;
		reg_addr_i = 2'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		repeat (2) @(posedge mclk_i);
		resetn_i <= 1'b1;
		t_shift();
		t_flags();
		t_bits();
		stop_test();
	end
endmodule : tb
